// >>> core/jlpc_top.sv
// jlpc_top: link framing parameter registers behind classic wishbone
// assumes one 200 MHz clock, synchronous reset, and a datapath that
// consumes the decoded framing values below
//
// Summary of operation
// - octets-per-frame byte resets to zero; frame size is code plus one
// - frames-per-multiframe five bits reset all ones; count is code plus one
// - converter byte resets to one; codes 0,1,3,7 give 1,2,4,8 converters
// - control-bit code appends none, bit 2, bits 2-1, or all three
// - resolution field holds bits minus one; reset selects sixteen bits
// - resolution code six gives seven bits; code seven gives eight
//
// The Wishbone slave port was chosen for this implementation.
`include "jlpc_cfg.svh"
`default_nettype none

module jlpc_top
	import jlpc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] adr_i,
	input wire jlpc_pkg::jlpc_word_type dat_i,
	output jlpc_pkg::jlpc_word_type dat_o,
	output logic ack_o,
	// decoded framing parameters
	output logic [8:0] frame_octets_o,
	output logic [5:0] mf_frames_o,
	output logic [8:0] converters_o,
	output logic [1:0] cs_count_o,
	output logic [2:0] ctrl_mask_o,
	output logic [5:0] res_bits_o,
	// framing sanity flags
	output logic fk_legal_o
);
	import jlpc_pkg::*;

	// stored fields, reserved bits are never held
	jlpc_byte_type f_q;
	logic [4:0] k_q;
	jlpc_byte_type m_q;
	logic [1:0] cs_q;
	logic [4:0] n_q;
	jlpc_byte_type f_d;
	logic [4:0] k_d;
	jlpc_byte_type m_d;
	logic [1:0] cs_d;
	logic [4:0] n_d;
	jlpc_word_type dat_q;
	jlpc_word_type dat_d;
	logic [3:0] status;

	// bus handshake
	logic req_new;
	logic wr;
	logic addr_ok;
	jlpc_idx_type idx;

	jlpc_wb_slave u_wb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.sel_i(sel_i),
		.adr_i(adr_i),
		.ack_o(ack_o),
		.req_new_o(req_new),
		.wr_o(wr),
		.addr_ok_o(addr_ok),
		.idx_o(idx)
	);

	// address decode into a one-hot selector
	function automatic jlpc_sel_type sel_of(input jlpc_idx_type i,
		input logic ok);
		if (!ok) begin
			sel_of = JLPC_SEL_NONE;
		end else begin
			case (i)
				`JLPC_IDX_F: sel_of = JLPC_SEL_F;
				`JLPC_IDX_K: sel_of = JLPC_SEL_K;
				`JLPC_IDX_M: sel_of = JLPC_SEL_M;
				`JLPC_IDX_CSN: sel_of = JLPC_SEL_CSN;
				`JLPC_IDX_STAT: sel_of = JLPC_SEL_STAT;
				default: sel_of = JLPC_SEL_NONE;
			endcase
		end
	endfunction : sel_of

	jlpc_sel_type sel;
	assign sel = sel_of(idx, addr_ok);

	// write enables; unmapped writes are acked and dropped
	wire wr_f = wr && (sel == JLPC_SEL_F);
	wire wr_k = wr && (sel == JLPC_SEL_K);
	wire wr_m = wr && (sel == JLPC_SEL_M);
	wire wr_csn = wr && (sel == JLPC_SEL_CSN);

	// next field values; only writable bits are taken
	assign f_d = wr_f ? dat_i[7:0] : f_q;
	assign k_d = wr_k ? dat_i[`JLPC_K_MSB:0] : k_q;
	assign m_d = wr_m ? dat_i[7:0] : m_q;
	assign cs_d = wr_csn ? dat_i[`JLPC_CS_MSB:`JLPC_CS_LSB] : cs_q;
	assign n_d = wr_csn ? dat_i[`JLPC_N_MSB:0] : n_q;

	// read mux, reserved bits padded with zero
	always_comb begin
		case (sel)
			JLPC_SEL_F: dat_d = {24'h000000, f_q};
			JLPC_SEL_K: dat_d = {24'h000000, 3'h0, k_q};
			JLPC_SEL_M: dat_d = {24'h000000, m_q};
			JLPC_SEL_CSN: dat_d = {24'h000000, cs_q, 1'b0, n_q};
			JLPC_SEL_STAT: dat_d = {28'h0000000, status};
			default: dat_d = 32'h00000000;
		endcase
	end

	// field storage with documented reset codes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f_q <= `JLPC_F_RST;
			k_q <= `JLPC_K_RST;
			m_q <= `JLPC_M_RST;
			cs_q <= `JLPC_CS_RST;
			n_q <= `JLPC_N_RST;
		end else begin
			f_q <= f_d;
			k_q <= k_d;
			m_q <= m_d;
			cs_q <= cs_d;
			n_q <= n_d;
		end
	end

	// read data latched with the request so it is steady under ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h00000000;
		end else if (req_new) begin
			dat_q <= dat_d;
		end
	end
	assign dat_o = dat_q;

	// decoding lags the fields by one cycle; the datapath should only
	// be restarted once configuration has settled
	jlpc_decode u_dec (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.f_code_i(f_q),
		.k_code_i(k_q),
		.m_code_i(m_q),
		.cs_code_i(cs_q),
		.n_code_i(n_q),
		.frame_octets_o(frame_octets_o),
		.mf_frames_o(mf_frames_o),
		.converters_o(converters_o),
		.cs_count_o(cs_count_o),
		.ctrl_mask_o(ctrl_mask_o),
		.res_bits_o(res_bits_o),
		.status_o(status)
	);

	// illegal frame/multiframe products are software's to avoid; the
	// flag only reports them, the datapath is not held off
	assign fk_legal_o = status[0];

	// checks on the stored and decoded parameters
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	f_reset_a:
	assert property ($past(rst_i) |-> f_q == 8'h00)
		else $error("octet field not zero after reset");

	f_plus_one_a:
	assert property (!$past(rst_i) |->
		frame_octets_o == ({1'b0, $past(f_q)} + 9'h001))
		else $error("frame octets not code plus one");

	f_sixteen_a:
	assert property ((f_q == 8'h0F) ##1 (f_q == 8'h0F) |->
		frame_octets_o == 9'h010)
		else $error("code fifteen did not give sixteen octets");

	k_reset_a:
	assert property ($past(rst_i) |-> k_q == 5'h1F ##1 mf_frames_o == 6'h20)
		else $error("multiframe field bad after reset");

	k_write_a:
	assert property (ack_o && we_i && cyc_i && stb_i && sel_i[0] &&
		sel == JLPC_SEL_K |=> k_q == $past(dat_i[4:0]) ##1
		mf_frames_o == ({1'b0, $past(dat_i[4:0], 2)} + 6'h01))
		else $error("multiframe write not applied and decoded");

	m_decode_a:
	assert property ($past(m_q) == 8'h03 && !$past(rst_i) |->
		converters_o == 9'h004)
		else $error("converter code three did not give four");

	m_eight_a:
	assert property ($past(m_q) == 8'h07 && !$past(rst_i) |->
		converters_o == 9'h008)
		else $error("converter code seven did not give eight");

	cs_mask_a:
	assert property ($past(cs_q) == 2'h2 && !$past(rst_i) |->
		ctrl_mask_o == 3'h6 && cs_count_o == 2'h2)
		else $error("two control bits not bits two and one");

	cs_one_a:
	assert property ($past(cs_q) == 2'h1 && !$past(rst_i) |->
		ctrl_mask_o == 3'h4)
		else $error("one control bit not bit two");

	res_sixteen_a:
	assert property ($past(n_q) == 5'h0F && !$past(rst_i) |->
		res_bits_o == 6'h10)
		else $error("resolution code fifteen not sixteen bits");

	res_seven_a:
	assert property ($past(n_q) == 5'h06 && !$past(rst_i) |->
		res_bits_o == 6'h07)
		else $error("resolution code six not seven bits");

	rsvd_read_a:
	assert property (ack_o && !we_i && (sel == JLPC_SEL_K ||
		sel == JLPC_SEL_CSN) |-> dat_o[7:5] == 3'h0 || sel == JLPC_SEL_CSN
		&& dat_o[5] == 1'b0)
		else $error("reserved bits read non-zero");

	ack_one_a:
	assert property (ack_o |=> !ack_o)
		else $error("ack held for more than one cycle");

	ack_data_a:
	assert property (cyc_i && stb_i && !ack_o |=> ack_o && dat_o ==
		$past(dat_d))
		else $error("read data not latched with the request");

	// reset codes, the supported decodes except resolution codes 9 to 14, and the reserved read bits;
	// read data is only looked at while ack stands, when it is valid
	m_reset_a:
	assert property ($past(rst_i) |-> m_q == 8'h01)
		else $error("converter field not one after reset");

	csn_reset_a:
	assert property ($past(rst_i) |-> cs_q == 2'h0 && n_q == 5'h0F)
		else $error("control or resolution field bad after reset");

	k_plus_one_a:
	assert property (!$past(rst_i) |->
		mf_frames_o == ({1'b0, $past(k_q)} + 6'h01))
		else $error("multiframe frames not code plus one");

	m_plus_one_a:
	assert property (!$past(rst_i) |->
		converters_o == ({1'b0, $past(m_q)} + 9'h001))
		else $error("converter count not code plus one");

	m_one_a:
	assert property ($past(m_q) == 8'h00 && !$past(rst_i) |->
		converters_o == 9'h001)
		else $error("converter code zero did not give one");

	m_two_a:
	assert property ($past(m_q) == 8'h01 && !$past(rst_i) |->
		converters_o == 9'h002)
		else $error("converter code one did not give two");

	cs_none_a:
	assert property ($past(cs_q) == 2'h0 && !$past(rst_i) |->
		ctrl_mask_o == 3'h0 && cs_count_o == 2'h0)
		else $error("zero control bits still appended some");

	cs_all_a:
	assert property ($past(cs_q) == 2'h3 && !$past(rst_i) |->
		ctrl_mask_o == 3'h7 && cs_count_o == 2'h3)
		else $error("three control bits not all appended");

	res_eight_a:
	assert property ($past(n_q) == 5'h07 && !$past(rst_i) |->
		res_bits_o == 6'h08)
		else $error("resolution code seven not eight bits");

	res_nine_a:
	assert property ($past(n_q) == 5'h08 && !$past(rst_i) |->
		res_bits_o == 6'h09)
		else $error("resolution code eight not nine bits");

	rsvd_k_a:
	assert property (ack_o && !we_i && sel == JLPC_SEL_K |->
		dat_o[31:5] == 27'h0000000)
		else $error("multiframe reserved bits read non-zero");

	rsvd_csn_a:
	assert property (ack_o && !we_i && sel == JLPC_SEL_CSN |->
		dat_o[31:8] == 24'h000000 && dat_o[5] == 1'b0)
		else $error("control register reserved bit read non-zero");

	// a write with the low byte lane off is acked but must not land
	sel_drop_a:
	assert property (ack_o && we_i && cyc_i && stb_i && !sel_i[0] |=>
		f_q == $past(f_q) && k_q == $past(k_q) && m_q == $past(m_q) &&
		cs_q == $past(cs_q) && n_q == $past(n_q))
		else $error("write with low byte lane off changed a field");
endmodule : jlpc_top

`default_nettype wire

// >>> core/jlpc_cfg.svh
// jlpc_cfg.svh: register indices, field positions, reset values
// assumes inclusion by bare name from the jlpc design files
`ifndef JLPC_CFG_SVH
`define JLPC_CFG_SVH

// register indices; byte address is four times the index
`define JLPC_IDX_F 12'h58C
`define JLPC_IDX_K 12'h58D
`define JLPC_IDX_M 12'h58E
`define JLPC_IDX_CSN 12'h58F
`define JLPC_IDX_STAT 12'h5C0

// field positions
`define JLPC_K_MSB 4
`define JLPC_CS_MSB 7
`define JLPC_CS_LSB 6
`define JLPC_N_MSB 4

// reset values
`define JLPC_F_RST 8'h00
`define JLPC_K_RST 5'h1F
`define JLPC_M_RST 8'h01
`define JLPC_CS_RST 2'h0
`define JLPC_N_RST 5'h0F

// response timing: ack follows the request by this many cycles
`define JLPC_ACK_LAT 1

`endif

// >>> core/jlpc_pkg.sv
// jlpc_pkg: types shared by the link parameter configuration block
// assumes jlpc_cfg.svh supplies the numeric constants
`default_nettype none

package jlpc_pkg;
	typedef logic [7:0] jlpc_byte_type;
	typedef logic [11:0] jlpc_idx_type;
	typedef logic [31:0] jlpc_word_type;
	// one-hot register selector
	typedef enum logic [5:0] {
		JLPC_SEL_NONE = 6'b000001,
		JLPC_SEL_F = 6'b000010,
		JLPC_SEL_K = 6'b000100,
		JLPC_SEL_M = 6'b001000,
		JLPC_SEL_CSN = 6'b010000,
		JLPC_SEL_STAT = 6'b100000
	} jlpc_sel_type;
endpackage : jlpc_pkg

`default_nettype wire

// >>> core/jlpc_wb_slave.sv
// jlpc_wb_slave: classic wishbone handshake for the parameter registers
// assumes a single-cycle classic master holding requests until ack
`default_nettype none

module jlpc_wb_slave
	import jlpc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone request
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] adr_i,
	// decoded request
	output logic ack_o,
	output logic req_new_o,
	output logic wr_o,
	output logic addr_ok_o,
	output jlpc_pkg::jlpc_idx_type idx_o
);
	logic ack_q;
	logic ack_d;
	wire req = cyc_i & stb_i;

	// ack one cycle after the request, dropped the cycle after
	assign ack_d = req & ~ack_q;
	assign ack_o = ack_q;
	assign req_new_o = req & ~ack_q;
	// write lands on the edge where the master samples ack
	assign wr_o = req & we_i & ack_q & sel_i[0];
	assign idx_o = adr_i[13:2];
	assign addr_ok_o = (adr_i[31:14] == 18'h00000) && (adr_i[1:0] == 2'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
		end
	end
endmodule : jlpc_wb_slave

`default_nettype wire

// >>> core/jlpc_decode.sv
// jlpc_decode: turns stored field codes into framing values
// assumes fields come from registers on the same clock
`default_nettype none

module jlpc_decode
	import jlpc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// stored fields
	input wire logic [7:0] f_code_i,
	input wire logic [4:0] k_code_i,
	input wire logic [7:0] m_code_i,
	input wire logic [1:0] cs_code_i,
	input wire logic [4:0] n_code_i,
	// decoded values
	output logic [8:0] frame_octets_o,
	output logic [5:0] mf_frames_o,
	output logic [8:0] converters_o,
	output logic [1:0] cs_count_o,
	output logic [2:0] ctrl_mask_o,
	output logic [5:0] res_bits_o,
	output logic [3:0] status_o
);
	// encoded count plus one, shared by octet and converter fields
	function automatic logic [8:0] plus_one(input logic [7:0] c);
		plus_one = {1'b0, c} + 9'h001;
	endfunction : plus_one

	// product of two counts modulo four only needs the low bits
	function automatic logic fk_ok(input logic [8:0] f, input logic [5:0] k);
		logic [3:0] p;
		p = {2'h0, f[1:0]} * {2'h0, k[1:0]};
		fk_ok = (p[1:0] == 2'h0);
	endfunction : fk_ok

	wire [8:0] f_val = plus_one(f_code_i);
	wire [5:0] k_val = {1'b0, k_code_i} + 6'h01;
	wire [8:0] m_val = plus_one(m_code_i);
	wire f_sup = (f_code_i == 8'h00) || (f_code_i == 8'h01) ||
		(f_code_i == 8'h02) || (f_code_i == 8'h03) ||
		(f_code_i == 8'h05) || (f_code_i == 8'h07) || (f_code_i == 8'h0F);
	wire m_sup = (m_code_i == 8'h00) || (m_code_i == 8'h01) ||
		(m_code_i == 8'h03) || (m_code_i == 8'h07);
	wire n_sup = (n_code_i >= 5'h06) && (n_code_i <= 5'h0F);
	wire [2:0] mask = (cs_code_i == 2'h0) ? 3'h0 :
		(cs_code_i == 2'h1) ? 3'h4 :
		(cs_code_i == 2'h2) ? 3'h6 : 3'h7;

	// registered so the datapath sees clean values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_octets_o <= 9'h001;
			mf_frames_o <= 6'h20;
			converters_o <= 9'h002;
			cs_count_o <= 2'h0;
			ctrl_mask_o <= 3'h0;
			res_bits_o <= 6'h10;
			status_o <= 4'h0;
		end else begin
			frame_octets_o <= f_val;
			mf_frames_o <= k_val;
			converters_o <= m_val;
			cs_count_o <= cs_code_i;
			ctrl_mask_o <= mask;
			res_bits_o <= {1'b0, n_code_i} + 6'h01;
			status_o <= {n_sup, m_sup, f_sup, fk_ok(f_val, k_val)};
		end
	end
endmodule : jlpc_decode

`default_nettype wire

// >>> sim/jlpc_top_bench.sv
// jlpc_top_bench: random and corner stimulus for the parameter registers
// assumes jlpc_top answers each classic wishbone cycle and is on one clock
`include "jlpc_cfg.svh"
`default_nettype none

module jlpc_top_bench
	import jlpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, fk_legal_o;
	logic [3:0] sel_i;
	logic [31:0] adr_i;
	jlpc_word_type dat_i, dat_o, rd;
	logic [8:0] frame_octets_o, converters_o;
	logic [5:0] mf_frames_o, res_bits_o;
	logic [1:0] cs_count_o, cs;
	logic [2:0] ctrl_mask_o;
	logic [4:0] nc;
	logic [7:0] rnd;
	logic [7:0] kc;
	int num_errors, tests_run, i;
	jlpc_idx_type ri [5] = '{`JLPC_IDX_F, `JLPC_IDX_K, `JLPC_IDX_M,
		`JLPC_IDX_CSN, `JLPC_IDX_STAT};
	jlpc_word_type rv [5] = '{32'h00, 32'h1F, 32'h01, 32'h0F, 32'h0F};
	jlpc_byte_type fc [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0F};
	jlpc_byte_type mc [4] = '{8'h00, 8'h01, 8'h03, 8'h07};

	jlpc_top i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .frame_octets_o(frame_octets_o),
		.mf_frames_o(mf_frames_o), .converters_o(converters_o),
		.cs_count_o(cs_count_o), .ctrl_mask_o(ctrl_mask_o),
		.res_bits_o(res_bits_o), .fk_legal_o(fk_legal_o)
	);

	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// repeatable pseudo-random bytes
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// frame length times multiframe length must divide by four
	function automatic logic fk_ok(input logic [7:0] f, input logic [4:0] k);
		return ((({1'b0, f} + 9'd1) * ({1'b0, k} + 6'd1)) % 4) == 0;
	endfunction : fk_ok

	// control bits appended, high bit first
	function automatic logic [2:0] mask_of(input logic [1:0] c);
		return (c == 2'h0) ? 3'h0 : (c == 2'h1) ? 3'h4 :
			(c == 2'h2) ? 3'h6 : 3'h7;
	endfunction : mask_of

	// verdict; the only place the run ends
	task finish_test;
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// register read-back comparison
	task chk_word(input jlpc_word_type got, input jlpc_word_type exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// decoded output comparison
	task chk_out(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_out

	// one classic cycle; bounded wait since a lost ack would hang the run
	task wb(input logic we, input jlpc_idx_type idx, input jlpc_byte_type wd,
		input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		sel_i <= sel;
		adr_i <= {18'h0, idx, 2'h0};
		dat_i <= {24'h0, wd};
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk_i);
		end
		if (ack_o !== 1'b1) begin
			num_errors++;
			finish_test();
		end else begin
			rd = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
		end
	endtask : wb

	// decoded outputs trail the stored field by a cycle
	task settle;
		repeat (3) @(posedge clk_i);
	endtask : settle

	// main sequence
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		sel_i = 4'h0;
		adr_i = 32'h0;
		dat_i = 32'h0;
		num_errors = 0;
		tests_run = 0;
		rnd = 8'h5E; // seed 94
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_out(frame_octets_o, 9'h001);
		chk_out({3'h0, mf_frames_o}, 9'h020);
		chk_out({3'h0, res_bits_o}, 9'h010);
		chk_out(converters_o, 9'h002);
		chk_out({6'h0, ctrl_mask_o}, 9'h000);
		chk_out({8'h0, fk_legal_o}, 9'h000);
		for (i = 0; i < 5; i++) begin
			wb(1'b0, ri[i], 8'h00, 4'h1);
			chk_word(rd, rv[i]);
		end
		$display("test reset done");
		// octet counts against random multiframe lengths
		foreach (fc[j]) begin
			rnd = lfsr(rnd);
			kc = rnd;
			// software keeps frame times multiframe a multiple of four
			if (!fk_ok(fc[j], kc[4:0])) begin
				kc[1:0] = 2'h3;
			end
			wb(1'b1, `JLPC_IDX_F, fc[j], 4'h1);
			wb(1'b1, `JLPC_IDX_K, kc, 4'h1);
			wb(1'b0, `JLPC_IDX_K, 8'h00, 4'h1);
			chk_word(rd, {27'h0, kc[4:0]});
			settle();
			chk_out(frame_octets_o, {1'b0, fc[j]} + 9'h001);
			chk_out({3'h0, mf_frames_o}, {4'h0, kc[4:0]} + 9'h001);
			chk_out({8'h0, fk_legal_o}, {8'h0, fk_ok(fc[j], kc[4:0])});
		end
		$display("test frame sizes done");
		foreach (mc[j]) begin
			wb(1'b1, `JLPC_IDX_M, mc[j], 4'h1);
			settle();
			chk_out(converters_o, {1'b0, mc[j]} + 9'd1);
		end
		$display("test converters done");
		// reserved bit written high must read back low
		for (i = 0; i < 10; i++) begin
			cs = 2'(i % 4);
			nc = 5'(6 + i);
			wb(1'b1, `JLPC_IDX_CSN, {cs, 1'b1, nc}, 4'h1);
			wb(1'b0, `JLPC_IDX_CSN, 8'h00, 4'h1);
			chk_word(rd, {24'h0, cs, 1'b0, nc});
			settle();
			chk_out({7'h0, cs_count_o}, {7'h0, cs});
			chk_out({6'h0, ctrl_mask_o}, {6'h0, mask_of(cs)});
			chk_out({3'h0, res_bits_o}, {4'h0, nc} + 9'd1);
		end
		$display("test control and resolution done");
		// lane-disabled write and unmapped access leave nothing behind
		wb(1'b1, `JLPC_IDX_F, 8'h03, 4'h0);
		wb(1'b1, 12'h590, lfsr(rnd), 4'h1);
		wb(1'b0, `JLPC_IDX_F, 8'h00, 4'h1);
		chk_word(rd, 32'h0F);
		wb(1'b0, 12'h590, 8'h00, 4'h1);
		chk_word(rd, 32'h00);
		// unsupported converter code is stored, decoded and flagged
		wb(1'b1, `JLPC_IDX_M, 8'h02, 4'h1);
		settle();
		chk_out(converters_o, 9'h003);
		wb(1'b0, `JLPC_IDX_STAT, 8'h00, 4'h1);
		chk_word(rd, 32'h0000000B);
		$display("test refused accesses done");
		finish_test();
	end
endmodule : jlpc_top_bench

`default_nettype wire
